/* logic/i2c_slave_with_timeout.sv */
// Two-wire bus slave with 7-bit address, clock stretching and bus time-out.
// Assumes open-drain pins resolved outside, and a slow clock far below clk_i.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_with_timeout
    import i2c_slave_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM register slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Two-wire link, open drain, enables active low
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    // Slow subsidiary clock for the time-out
    input  wire logic        sub_clk_i,
    // Interface interrupt
    output var  logic        irq_o
);

    // Two-flop synchronisers, plus one history flop for edge detection
    logic scl_m, scl_s, scl_q;
    logic sda_m, sda_s, sda_q;
    logic sub_m, sub_s, sub_q;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
            {sub_m, sub_s, sub_q} <= 3'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
            {sub_m, sub_s, sub_q} <= {sub_clk_i, sub_m, sub_s};
        end
    end

    // Bus events seen on the synchronised lines
    logic scl_rise, scl_fall, start_det, stop_det, sub_tick;
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
    assign sub_tick  = sub_s & ~sub_q;

    // Bus handshake: one wait cycle, then the access is accepted
    logic bus_ack, next_bus_ack, wr_acc, rd_acc, req;
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~bus_ack;
    assign wr_acc            = avs_write_i & bus_ack & avs_byteenable_i[0];
    assign rd_acc            = avs_read_i & bus_ack;
    assign next_bus_ack      = req & ~bus_ack;

    // Register and link state
    link_state_t          state, next_state;
    logic [2:0]           bit_cnt, next_bit_cnt;
    logic [7:0]           shift_data_reg, next_shift_data_reg;
    logic [6:0]           own_addr, next_own_addr;
    logic                 link_enable, next_link_enable;
    logic                 bus_busy_flag, next_bus_busy_flag;
    logic                 addr_match_flag, next_addr_match_flag;
    logic                 master_dir_flag, next_master_dir_flag;
    logic                 xmit_mode_sel, next_xmit_mode_sel;
    logic                 ack_to_send, next_ack_to_send;
    logic                 ack_received, next_ack_received;
    logic                 sda_low, next_sda_low;
    logic                 scl_low, next_scl_low;
    logic                 next_irq;
    logic                 tmo_enable, next_tmo_enable;
    logic                 tmo_flag, next_tmo_flag;
    logic [TMO_SEL_W-1:0] tmo_period_sel, next_tmo_period_sel;
    logic [TMO_CNT_W-1:0] tmo_cnt, next_tmo_cnt;
    logic [31:0]          next_readdata;
    logic                 release_evt;

    // Software services the data register to let the stretched clock go
    assign release_evt = (avs_address_i == OFS_DATA) &
                         ((wr_acc & xmit_mode_sel) | (rd_acc & ~xmit_mode_sel));

    // Next state of the registers, the link sequencer and the time-out
    always_comb
    begin
        next_state           = state;
        next_bit_cnt         = bit_cnt;
        next_shift_data_reg  = shift_data_reg;
        next_own_addr        = own_addr;
        next_link_enable     = link_enable;
        next_bus_busy_flag   = bus_busy_flag;
        next_addr_match_flag = addr_match_flag;
        next_master_dir_flag = master_dir_flag;
        next_xmit_mode_sel   = xmit_mode_sel;
        next_ack_to_send     = ack_to_send;
        next_ack_received    = ack_received;
        next_sda_low         = sda_low;
        next_scl_low         = scl_low;
        next_irq             = 1'b0;
        next_tmo_enable      = tmo_enable;
        next_tmo_flag        = tmo_flag;
        next_tmo_period_sel  = tmo_period_sel;
        next_tmo_cnt         = tmo_cnt;

        // Software writes, low byte lane only
        if (wr_acc)
        begin
            case (avs_address_i)
                OFS_CTRL_FIRST:
                    next_link_enable = avs_writedata_i[CF_ENABLE_BIT];
                OFS_CTRL_SECOND:
                begin
                    next_xmit_mode_sel = avs_writedata_i[CS_XMIT_BIT];
                    next_ack_to_send   = avs_writedata_i[CS_ACK_SEND_BIT];
                end
                OFS_OWN_ADDR:
                    next_own_addr = avs_writedata_i[7:OA_ADDR_LSB];
                OFS_DATA:
                    next_shift_data_reg = avs_writedata_i[7:0];
                OFS_TMO_CTRL:
                begin
                    next_tmo_enable     = avs_writedata_i[TC_ENABLE_BIT];
                    // Writing zero clears; a write of one cannot set it
                    next_tmo_flag       = tmo_flag & avs_writedata_i[TC_FLAG_BIT];
                    next_tmo_period_sel = avs_writedata_i[TMO_SEL_W-1:0];
                end
                default:
                    ;
            endcase
        end

        // Bus conditions take priority over the bit sequencer
        if (start_det)
        begin
            next_bus_busy_flag = 1'b1;
            next_state         = link_enable ? ST_ADDR : ST_IDLE;
            next_bit_cnt       = 3'h0;
            next_sda_low       = 1'b0;
            next_scl_low       = 1'b0;
        end
        else if (stop_det)
        begin
            next_bus_busy_flag   = 1'b0;
            next_state           = ST_IDLE;
            next_addr_match_flag = 1'b0;
            next_sda_low         = 1'b0;
            next_scl_low         = 1'b0;
        end
        else if (!link_enable)
        begin
            next_state   = ST_IDLE;
            next_sda_low = 1'b0;
            next_scl_low = 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    ;
                // Seven address bits then direction, sampled on rising SCL
                ST_ADDR:
                    if (scl_rise)
                    begin
                        next_shift_data_reg = {shift_data_reg[6:0], sda_s};
                        next_bit_cnt        = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7)
                        begin
                            if (shift_data_reg[6:0] == own_addr)
                            begin
                                next_addr_match_flag = 1'b1;
                                next_master_dir_flag = sda_s;
                                next_irq             = 1'b1;
                                next_state           = ST_ADDR_ACK;
                            end
                            else
                                next_state = ST_IDLE;
                        end
                    end
                // Drive low through the ninth clock, then stretch SCL
                ST_ADDR_ACK:
                    if (scl_fall)
                    begin
                        if (bit_cnt == 3'h0)
                        begin
                            next_sda_low = 1'b1;
                            next_bit_cnt = 3'h1;
                        end
                        else
                        begin
                            next_sda_low = 1'b0;
                            next_scl_low = 1'b1;
                            next_state   = ST_HOLD;
                        end
                    end
                // SCL held low until the data register is serviced
                ST_HOLD:
                    if (release_evt)
                    begin
                        next_scl_low         = 1'b0;
                        next_addr_match_flag = 1'b0;
                        next_bit_cnt         = 3'h0;
                        if (xmit_mode_sel)
                        begin
                            next_state   = ST_TX;
                            next_sda_low = ~next_shift_data_reg[7];
                        end
                        else
                            next_state = ST_RX;
                    end
                // Next bit presented after each falling SCL
                ST_TX:
                    if (scl_fall)
                    begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7)
                        begin
                            next_sda_low = 1'b0;
                            next_state   = ST_TX_ACK;
                        end
                        else
                        begin
                            next_shift_data_reg = {shift_data_reg[6:0], 1'b0};
                            next_sda_low        = ~shift_data_reg[6];
                        end
                    end
                // Master answer; a missing acknowledge leaves SDA free
                ST_TX_ACK:
                    if (scl_rise)
                        next_ack_received = sda_s;
                    else if (scl_fall)
                    begin
                        next_irq = 1'b1;
                        if (!ack_received)
                        begin
                            next_scl_low = 1'b1;
                            next_state   = ST_HOLD;
                        end
                        else
                            next_state = ST_IDLE;
                    end
                // Received bits land in the data register
                ST_RX:
                    if (scl_rise)
                    begin
                        next_shift_data_reg = {shift_data_reg[6:0], sda_s};
                        next_bit_cnt        = bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7)
                        begin
                            next_irq   = 1'b1;
                            next_state = ST_RX_ACK;
                        end
                    end
                ST_RX_ACK:
                    if (scl_fall)
                    begin
                        if (bit_cnt == 3'h0)
                        begin
                            next_sda_low = ~ack_to_send;
                            next_bit_cnt = 3'h1;
                        end
                        else
                        begin
                            next_sda_low = 1'b0;
                            next_scl_low = 1'b1;
                            next_state   = ST_HOLD;
                        end
                    end
            endcase
        end

        // Time-out: restarts on every SCL edge, counts slow clock periods
        if (!(tmo_enable && bus_busy_flag) || scl_rise || scl_fall)
            next_tmo_cnt = '0;
        else if (sub_tick)
        begin
            if (tmo_cnt == {tmo_period_sel, STEP_LAST})
            begin
                // Overflow wins over a same-cycle write to the second control register or to the time-out enable and flag
                next_tmo_cnt         = '0;
                next_tmo_enable      = 1'b0;
                next_tmo_flag        = 1'b1;
                next_irq             = 1'b1;
                next_state           = ST_IDLE;
                next_bit_cnt         = 3'h0;
                next_sda_low         = 1'b0;
                next_scl_low         = 1'b0;
                next_addr_match_flag = CTRL_SECOND_RST[CS_ADDR_MATCH_BIT];
                next_bus_busy_flag   = CTRL_SECOND_RST[CS_BUS_BUSY_BIT];
                next_xmit_mode_sel   = CTRL_SECOND_RST[CS_XMIT_BIT];
                next_ack_to_send     = CTRL_SECOND_RST[CS_ACK_SEND_BIT];
                next_master_dir_flag = CTRL_SECOND_RST[CS_DIR_BIT];
                next_ack_received    = CTRL_SECOND_RST[CS_ACK_RCVD_BIT];
            end
            else
                next_tmo_cnt = tmo_cnt + TMO_CNT_W'(1);
        end
    end

    // Read data mux, registered during the wait cycle
    always_comb
    begin
        next_readdata = avs_readdata_o;
        if (avs_read_i && !bus_ack)
        begin
            next_readdata = 32'h0000_0000;
            case (avs_address_i)
                OFS_CTRL_FIRST:
                    next_readdata[CF_ENABLE_BIT] = link_enable;
                OFS_CTRL_SECOND:
                begin
                    next_readdata[CS_ADDR_MATCH_BIT] = addr_match_flag;
                    next_readdata[CS_BUS_BUSY_BIT]   = bus_busy_flag;
                    next_readdata[CS_XMIT_BIT]       = xmit_mode_sel;
                    next_readdata[CS_ACK_SEND_BIT]   = ack_to_send;
                    next_readdata[CS_DIR_BIT]        = master_dir_flag;
                    next_readdata[CS_ACK_RCVD_BIT]   = ack_received;
                end
                OFS_OWN_ADDR:
                    next_readdata[7:0] = {own_addr, 1'b0};
                OFS_DATA:
                    next_readdata[7:0] = shift_data_reg;
                OFS_TMO_CTRL:
                    next_readdata[7:0] = {tmo_enable, tmo_flag, tmo_period_sel};
                default:
                    next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // Register everything
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            bus_ack         <= 1'b0;
            avs_readdata_o  <= 32'h0000_0000;
            state           <= ST_IDLE;
            bit_cnt         <= 3'h0;
            shift_data_reg  <= DATA_RST;
            own_addr        <= OWN_ADDR_RST;
            link_enable     <= CTRL_FIRST_RST[CF_ENABLE_BIT];
            bus_busy_flag   <= CTRL_SECOND_RST[CS_BUS_BUSY_BIT];
            addr_match_flag <= CTRL_SECOND_RST[CS_ADDR_MATCH_BIT];
            master_dir_flag <= CTRL_SECOND_RST[CS_DIR_BIT];
            xmit_mode_sel   <= CTRL_SECOND_RST[CS_XMIT_BIT];
            ack_to_send     <= CTRL_SECOND_RST[CS_ACK_SEND_BIT];
            ack_received    <= CTRL_SECOND_RST[CS_ACK_RCVD_BIT];
            sda_low         <= 1'b0;
            scl_low         <= 1'b0;
            irq_o           <= 1'b0;
            tmo_enable      <= TMO_CTRL_RST[TC_ENABLE_BIT];
            tmo_flag        <= TMO_CTRL_RST[TC_FLAG_BIT];
            tmo_period_sel  <= TMO_CTRL_RST[TMO_SEL_W-1:0];
            tmo_cnt         <= '0;
        end
        else
        begin
            bus_ack         <= next_bus_ack;
            avs_readdata_o  <= next_readdata;
            state           <= next_state;
            bit_cnt         <= next_bit_cnt;
            shift_data_reg  <= next_shift_data_reg;
            own_addr        <= next_own_addr;
            link_enable     <= next_link_enable;
            bus_busy_flag   <= next_bus_busy_flag;
            addr_match_flag <= next_addr_match_flag;
            master_dir_flag <= next_master_dir_flag;
            xmit_mode_sel   <= next_xmit_mode_sel;
            ack_to_send     <= next_ack_to_send;
            ack_received    <= next_ack_received;
            sda_low         <= next_sda_low;
            scl_low         <= next_scl_low;
            irq_o           <= next_irq;
            tmo_enable      <= next_tmo_enable;
            tmo_flag        <= next_tmo_flag;
            tmo_period_sel  <= next_tmo_period_sel;
            tmo_cnt         <= next_tmo_cnt;
        end
    end

    // Open drain: only ever pull low, enable low while pulling
    assign sda_o      = 1'b0;
    assign scl_o      = 1'b0;
    assign sda_oe_n_o = ~sda_low;
    assign scl_oe_n_o = ~scl_low;

endmodule // i2c_slave_with_timeout

`default_nettype wire

/* logic/i2c_slave_pkg.sv */
// Shared constants for the two-wire slave with bus time-out.
// Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
`default_nettype none

package i2c_slave_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_CTRL_FIRST  = 5'h00;
    localparam logic [4:0] OFS_CTRL_SECOND = 5'h04;
    localparam logic [4:0] OFS_OWN_ADDR    = 5'h08;
    localparam logic [4:0] OFS_DATA        = 5'h0c;
    localparam logic [4:0] OFS_TMO_CTRL    = 5'h10;

    // First control register fields
    localparam int CF_ENABLE_BIT = 0;

    // Second control register fields
    localparam int CS_ADDR_MATCH_BIT = 7;
    localparam int CS_BUS_BUSY_BIT   = 6;
    localparam int CS_XMIT_BIT       = 5;
    localparam int CS_ACK_SEND_BIT   = 4;
    localparam int CS_DIR_BIT        = 3;
    localparam int CS_ACK_RCVD_BIT   = 2;

    // Own address register: address in bits 7..1, bit 0 reads zero
    localparam int OA_ADDR_LSB = 1;

    // Time-out control register fields
    localparam int TC_ENABLE_BIT = 7;
    localparam int TC_FLAG_BIT   = 6;
    localparam int TMO_SEL_W     = 6;

    // Reset values
    localparam logic [7:0] CTRL_FIRST_RST  = 8'h00;
    localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
    localparam logic [6:0] OWN_ADDR_RST    = 7'h00;
    localparam logic [7:0] DATA_RST        = 8'h00;
    localparam logic [7:0] TMO_CTRL_RST    = 8'h00;

    // Slow clock periods per time-out step
    localparam int SUB_TICKS_PER_STEP = 32;
    localparam int STEP_W             = $clog2(SUB_TICKS_PER_STEP);
    localparam int TMO_CNT_W          = TMO_SEL_W + STEP_W;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(SUB_TICKS_PER_STEP - 1);

    // Link sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_HOLD,
        ST_TX,
        ST_TX_ACK,
        ST_RX,
        ST_RX_ACK
    } link_state_t;

endpackage

`default_nettype wire

/* bench/i2c_master_model.sv */
// Behavioural two-wire master: START, STOP and byte transfers.
// Assumes the bench resolves the wired-AND lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
    // Resolved wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Master drive, high releases the line
    output logic      scl_o,
    output logic      sda_o
);
    // Lines released between frames, so the clock stands still
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Offset of 7 ns keeps edges clear of the system clock
    task automatic start();
        #7 sda_o = 1'b0;
        #60 scl_o = 1'b0;
    endtask
    // Low phase 100 ns so the slave's late SDA change still lands early
    task automatic bit_x(input logic b, output logic r);
        #40 sda_o = b;
        #60 scl_o = 1'b1;
        wait (scl_i === 1'b1);
        #60 r = sda_i;
        scl_o = 1'b0;
    endtask
    // Eight bits most significant first, then the acknowledge bit
    task automatic byte_x(input logic [7:0] d, input logic k, output logic [7:0] q,
                          output logic a);
        #7; // Calls may arrive on a clock edge; step clear of it
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(k, a);
    endtask
    // SDA rises with SCL high; also ends a transfer left without acknowledge
    task automatic stop();
        #47 sda_o = 1'b0;
        #60 scl_o = 1'b1;
        wait (scl_i === 1'b1);
        #60 sda_o = 1'b1;
        #60;
    endtask
endmodule // i2c_master_model
`default_nettype wire

/* bench/i2c_slave_with_timeout_sva.sv */
// Checker for the slave: bus handshake, stretch release and pin timing.
// Assumes scl_i is the resolved wire, the device's own drive included.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_sva
    import i2c_slave_pkg::*;
(
    // Clock, reset and register bus
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // Link pins and interrupt
    input wire logic        scl_i,
    input wire logic        scl_oe_n_o,
    input wire logic        sda_oe_n_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Accepted accesses
    sequence s_acc;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    sequence s_rd;
        s_acc ##0 avs_read_i;
    endsequence
    AST_ONE_WAIT:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait state not single");
    AST_IRQ_PULSE:
        assert property (irq_o |=> !irq_o) else $error("interrupt pulse too long");
    AST_NO_START:
        assert property ($fell(sda_oe_n_o) |-> !scl_i) else $error("SDA pulled with SCL high");
    AST_NO_STOP:
        assert property ($rose(sda_oe_n_o) |-> !scl_i) else $error("SDA freed with SCL high");
    AST_STRETCH_SDA_FREE:
        assert property (!scl_oe_n_o |-> sda_oe_n_o) else $error("SDA held during stretch");
    AST_RELEASE:
        assert property (s_acc ##0 avs_address_i == OFS_DATA && !scl_oe_n_o |=> scl_oe_n_o)
        else $error("data access kept SCL low");
    AST_HOLD:
        assert property ($rose(scl_oe_n_o) |-> irq_o || $past(irq_o) || $past((avs_read_i
            || avs_write_i) && !avs_waitrequest_o && avs_address_i == OFS_DATA))
        else $error("SCL freed without cause");
    AST_OWN_BIT0:
        assert property (s_rd ##0 avs_address_i == OFS_OWN_ADDR |-> !avs_readdata_o[0])
        else $error("address bit 0 not zero");
    AST_UNMAPPED:
        assert property (s_rd ##0 avs_address_i > OFS_TMO_CTRL |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // i2c_slave_sva
`default_nettype wire

/* bench/test_i2c_slave_with_timeout.sv */
// Self-checking bench: register rows, then receive, transmit and time-out.
// Assumes the master model and checker compile ahead of it.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_with_timeout;
    import i2c_slave_pkg::*;
    typedef struct packed {logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, sub_clk_i = 1'b0;
    logic        avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o, irq_o;
    logic [4:0]  avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic        scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, m_scl, m_sda, scl_w, sda_w, a;
    logic [7:0]  q;
    int          num_errors = 0, check_count = 0, irq_cnt = 0, cyc = 0, n;
    row_t        rows [5] = '{'{OFS_CTRL_SECOND, 8'hff, 8'h30}, '{OFS_TMO_CTRL, 8'h3f, 8'h3f},
        '{OFS_OWN_ADDR, 8'hb5, 8'hb4}, '{5'h14, 8'hff, 8'h00}, '{OFS_CTRL_FIRST, 8'h01, 8'h01}};
    // Wired-AND with pull-ups: a released line reads high
    assign scl_w = m_scl & (scl_oe_n_o | scl_o);
    assign sda_w = m_sda & (sda_oe_n_o | sda_o);
    initial forever #10 clk_i = ~clk_i;
    initial forever #20 sub_clk_i = ~sub_clk_i;
    i2c_slave_with_timeout i2c_slave_with_timeout_inst (.clk_i, .sys_rst_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
        .avs_waitrequest_o, .scl_i(scl_w), .scl_o, .scl_oe_n_o, .sda_i(sda_w), .sda_o,
        .sda_oe_n_o, .sub_clk_i, .irq_o);
    i2c_master_model i2c_master_model_inst (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl),
        .sda_o(m_sda));
    // Interrupt pulses counted at mid-cycle, clear of the launching edge
    always @(negedge clk_i)
        if (irq_o === 1'b1)
            irq_cnt++;
    // Hang guard: the whole run needs under a thousand cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            test_done();
        end
    end
    // One access, held until waitrequest is seen low at a rising edge
    task automatic avs(input logic w, input logic [4:0] ad, input logic [7:0] d);
        @(posedge clk_i);
        avs_address_i <= ad;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        foreach (rows[i])
        begin
            avs(1'b1, rows[i].a, rows[i].d);
            avs(1'b0, rows[i].a, 8'h00);
            chk(q, rows[i].e);
        end
        $display("register rows done");
        // Mid-run reset returns the registers to zero
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            avs(1'b0, 5'(i * 4), 8'h00);
            chk(q, 8'h00);
        end
        avs(1'b1, OFS_CTRL_FIRST, 8'h01);
        avs(1'b1, OFS_OWN_ADDR, 8'hb5);
        $display("reset done");
        // Foreign address is ignored, then a written byte is received
        i2c_master_model_inst.start();
        i2c_master_model_inst.byte_x(8'h22, 1'b1, q, a);
        chk({7'h0, a}, 8'h01);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.start();
        i2c_master_model_inst.byte_x(8'hb4, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        chk(8'(irq_cnt), 8'h01);
        avs(1'b0, OFS_CTRL_SECOND, 8'h00);
        chk(q, 8'hc0);
        avs(1'b0, OFS_DATA, 8'h00);
        chk(q, 8'hb4);
        i2c_master_model_inst.byte_x(8'hc3, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        // A read before the stretch starts is no release, so wait for it
        wait (scl_oe_n_o === 1'b0);
        avs(1'b0, OFS_DATA, 8'h00);
        chk(q, 8'hc3);
        i2c_master_model_inst.stop();
        avs(1'b0, OFS_CTRL_SECOND, 8'h00);
        chk(q, 8'h00);
        $display("receive done");
        // Master reads one byte and refuses it
        i2c_master_model_inst.start();
        i2c_master_model_inst.byte_x(8'hb5, 1'b1, q, a);
        avs(1'b0, OFS_CTRL_SECOND, 8'h00);
        chk(q, 8'hc8);
        avs(1'b1, OFS_CTRL_SECOND, 8'h20);
        avs(1'b1, OFS_DATA, 8'h96);
        i2c_master_model_inst.byte_x(8'hff, 1'b1, q, a);
        chk(q, 8'h96);
        avs(1'b0, OFS_CTRL_SECOND, 8'h00);
        chk(q & 8'h0c, 8'h0c);
        i2c_master_model_inst.stop();
        $display("transmit done");
        // Stalled link: selection 1 gives 64 slow periods, 128 system cycles
        avs(1'b1, OFS_CTRL_SECOND, 8'h00);
        i2c_master_model_inst.start();
        i2c_master_model_inst.byte_x(8'hb4, 1'b1, q, a);
        avs(1'b1, OFS_TMO_CTRL, 8'h81);
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (irq_o !== 1'b1 && n < 400);
        chk(8'(n >= 124 && n <= 140), 8'h01);
        chk({7'h0, scl_oe_n_o}, 8'h01);
        avs(1'b0, OFS_TMO_CTRL, 8'h00);
        chk(q, 8'h41);
        avs(1'b0, OFS_CTRL_SECOND, 8'h00);
        chk(q, 8'h00);
        avs(1'b0, OFS_OWN_ADDR, 8'h00);
        chk(q, 8'hb4);
        avs(1'b1, OFS_TMO_CTRL, 8'h01);
        avs(1'b0, OFS_TMO_CTRL, 8'h00);
        chk(q, 8'h01);
        i2c_master_model_inst.stop();
        $display("time-out done");
        test_done();
    end
endmodule // test_i2c_slave_with_timeout
bind i2c_slave_with_timeout i2c_slave_sva i2c_slave_sva_inst (.clk_i, .sys_rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .scl_i,
    .scl_oe_n_o, .sda_oe_n_o, .irq_o);
`default_nettype wire
